// File: hw/sar_adc_pkg.sv
// constants and types shared by the converter control block
package sar_adc_pkg;
  // register map (word offsets on the plain register port)
  localparam logic [3:0] ADDR_CONTROL_0 = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_1 = 4'h1;
  localparam logic [3:0] ADDR_RESULT_HI = 4'h2;
  localparam logic [3:0] ADDR_RESULT_LO = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;
  // control 0 fields
  localparam int CTL0_ENABLE_BIT = 0;
  localparam int CTL0_GO_BIT     = 1;
  localparam int CTL0_CHS_LSB    = 2;
  localparam int CHS_W           = 6;
  // control 1 fields
  localparam int CTL1_PREF_LSB   = 0;
  localparam int CTL1_NREF_BIT   = 2;
  localparam int CTL1_FMT_BIT    = 7;
  // converter geometry
  localparam int RES_W           = 10;
  localparam int DATA_W          = 8;
  localparam logic [3:0] BIT_LAST = 4'h9;
  // one bit decision per this many system clocks
  localparam int TBIT_NS         = 1000;
  localparam int CLK_NS          = 5;
  localparam int TBIT_CYC        = (TBIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TBIT_LAST = 8'(TBIT_CYC - 1);
  // positive reference encodings
  localparam logic [1:0] PREF_VDD     = 2'h0;
  localparam logic [1:0] PREF_PIN     = 2'h1;
  localparam logic [1:0] PREF_FVR_LO  = 2'h2;
  localparam logic [1:0] PREF_FVR_HI  = 2'h3;
  // channel codes
  localparam logic [5:0] CH_GROUND    = 6'h3C;
  localparam logic [5:0] CH_TEMP      = 6'h3D;
  localparam logic [5:0] CH_DAC       = 6'h3E;
  localparam logic [5:0] CH_FVR       = 6'h3F;
  localparam logic [5:0] CH_PORTC_LO  = 6'h10;
  localparam logic [5:0] CH_PORTC_HI  = 6'h17;
  localparam logic [5:0] CH_PORTC_SML = 6'h15;
  localparam logic [5:0] CH_PORTB_LO  = 6'h0C;
  localparam logic [5:0] CH_PORTB_HI  = 6'h0F;
  localparam logic [5:0] CH_PORTA_HI  = 6'h05;
  localparam logic [5:0] CH_PORTA_GAP = 6'h03;
  localparam logic [5:0] CH_NONE      = 6'h00;
  // converter states
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;
endpackage : sar_adc_pkg

// File: hw/sar_adc_config_control.sv
// control and configuration logic of the 10-bit converter
// Behaviour
// (R01) ten-bit approximation result into result pair
// (R02) six-bit field picks the sampled source
// (R03) legal channels depend on the variant
// (R04) software waits settling after channel change
// (R05) software passes through ground when stepping down
// (R06) two-bit field picks positive reference
// (R07) one bit picks negative reference
// (R08) completion raises interrupt, wakes from sleep
// (R09) software sets pins analog before converting
// (R10) done clears go, sets flag, loads results
// (R11) format bit picks left or right justify
// (R12) enable first, then start, separately
// (R13) reference codes follow the listed order
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_config_control #(
  parameter bit LARGE_VARIANT = 1'b1,  // 1: larger pin count part
  parameter bit LOW_VOLTAGE   = 1'b0   // 1: high fixed reference absent
) (
  // clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  // register port
  input  wire logic [3:0]                     i_addr,
  input  wire logic [sar_adc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic [sar_adc_pkg::DATA_W-1:0]      o_rdata,
  // analog front end
  input  wire logic                           i_cmp,
  output logic [sar_adc_pkg::RES_W-1:0]       o_dac_code,
  output logic [sar_adc_pkg::CHS_W-1:0]       o_channel_select,
  output logic                                o_channel_valid,
  output logic                                o_sample,
  output logic [1:0]                          o_positive_ref_select,
  output logic                                o_negative_ref_select,
  // interrupt and wake
  output logic                                o_irq,
  output logic                                o_wake
);
  import sar_adc_pkg::*;

  // all state of the block
  typedef struct packed {
    conv_state_t         state;
    logic                module_enable_bit;
    logic                go;
    logic [CHS_W-1:0]    channel_select;
    logic [1:0]          positive_ref_select;
    logic                negative_ref_select;
    logic                result_format_bit;
    logic [RES_W-1:0]    sar;         // trial and decided bits
    logic [3:0]          bit_idx;     // bits decided so far
    logic [7:0]          tick;        // clocks inside one bit period
    logic [RES_W-1:0]    result;      // last stored result
    logic                conversion_done_flag;
    logic                done_mask;
    logic [DATA_W-1:0]   rdata;
  } state_t;

  state_t cur;   // registered state
  state_t nxt;   // next value

  logic               chan_ok;      // selected code exists on this variant
  logic [DATA_W-1:0]  result_high_reg;
  logic [DATA_W-1:0]  result_low_reg;
  logic [RES_W-1:0]   decided;     // current trial with this bit resolved
  logic [RES_W-1:0]   onehot;      // weight of the bit under trial
  logic               go_write;    // software writes go this cycle
  logic               done_event;  // last bit decided this cycle

  // channel legality per variant
  always_comb begin
    unique case (1'b1)
      cur.channel_select <= CH_PORTA_HI:
        chan_ok = (cur.channel_select != CH_PORTA_GAP); // R03
      cur.channel_select >= CH_PORTB_LO && cur.channel_select <= CH_PORTB_HI:
        chan_ok = LARGE_VARIANT; // R03
      cur.channel_select >= CH_PORTC_LO && cur.channel_select <= CH_PORTC_HI:
        chan_ok = LARGE_VARIANT || (cur.channel_select <= CH_PORTC_SML); // R03
      cur.channel_select >= CH_GROUND:
        chan_ok = 1'b1; // R03
      default:
        chan_ok = 1'b0;
    endcase
  end

  // result pair layout by format bit
  always_comb begin
    if (cur.result_format_bit) begin
      // right justified: two msbs in the high byte
      result_high_reg = {6'h00, cur.result[9:8]}; // R11
      result_low_reg  = cur.result[7:0];          // R11
    end else begin
      // left justified: two lsbs at the top of the low byte
      result_high_reg = cur.result[9:2];          // R11
      result_low_reg  = {cur.result[1:0], 6'h00}; // R11
    end
  end

  // bit weight and resolved trial
  always_comb begin
    onehot  = RES_W'(10'h200 >> cur.bit_idx);
    // the comparator only counts on the last clock of a bit period,
    // so the trial code has a whole period to settle
    decided = i_cmp ? cur.sar : (cur.sar & ~onehot); // R01
  end

  assign go_write = i_wr && (i_addr == ADDR_CONTROL_0)
                    && i_wdata[CTL0_GO_BIT];

  // completion of a live conversion, used to let the flag set win
  assign done_event = (cur.state == ST_CONV) && cur.go
                      && cur.module_enable_bit
                      && (cur.tick == TBIT_LAST)
                      && (cur.bit_idx == BIT_LAST);

  // next state
  always_comb begin
    nxt = cur;
    nxt.rdata = '0;
    // register writes
    if (i_wr) begin
      case (i_addr)
        ADDR_CONTROL_0: begin
          nxt.module_enable_bit = i_wdata[CTL0_ENABLE_BIT];
          nxt.channel_select =
            i_wdata[CTL0_CHS_LSB +: CHS_W]; // R02
          nxt.go = i_wdata[CTL0_GO_BIT] && cur.module_enable_bit; // R12
        end
        ADDR_CONTROL_1: begin
          nxt.positive_ref_select = i_wdata[CTL1_PREF_LSB +: 2]; // R06
          nxt.negative_ref_select = i_wdata[CTL1_NREF_BIT];      // R07
          nxt.result_format_bit   = i_wdata[CTL1_FMT_BIT];       // R11
        end
        ADDR_IRQ_MASK: nxt.done_mask = i_wdata[0];
        default: ;
      endcase
    end
    // sequencer
    case (cur.state)
      ST_OFF: begin
        if (cur.module_enable_bit)
          nxt.state = ST_IDLE;
      end
      ST_IDLE: begin
        if (!cur.module_enable_bit) begin
          nxt.state = ST_OFF;
        end else if (cur.go) begin
          nxt.state   = ST_CONV;
          nxt.sar     = 10'h200;
          nxt.bit_idx = 4'h0;
          nxt.tick    = 8'h00;
        end
      end
      ST_CONV: begin
        if (!cur.module_enable_bit || !cur.go) begin
          // aborted: store partial, fill undecided bits with last one
          nxt.state  = cur.module_enable_bit ? ST_IDLE : ST_OFF;
          nxt.go     = 1'b0;
          nxt.result = (cur.bit_idx == 4'h0) ? '0 :
            ((cur.sar & ~onehot) |
             ({RES_W{cur.sar[RES_W - 32'(cur.bit_idx)]}} &
              (onehot | (onehot - 10'h001))));
        end else if (cur.tick != TBIT_LAST) begin
          nxt.tick = cur.tick + 8'h01;
        end else begin
          nxt.tick    = 8'h00;
          nxt.bit_idx = cur.bit_idx + 4'h1;
          if (cur.bit_idx == BIT_LAST) begin
            nxt.state  = ST_IDLE;
            nxt.go     = go_write;              // R10
            nxt.result = decided;               // R01 R10
            nxt.conversion_done_flag = 1'b1;    // R10 R08
          end else begin
            nxt.sar = decided | (onehot >> 1);  // R01
          end
        end
      end
      default: nxt.state = ST_OFF;
    endcase
    // write one to clear; a completion in the same cycle wins so
    // that no finished conversion is ever lost
    if (i_wr && i_addr == ADDR_IRQ_STAT && i_wdata[0] && !done_event)
      nxt.conversion_done_flag = 1'b0; // R10
    // read data one cycle later
    if (i_rd) begin
      case (i_addr)
        ADDR_CONTROL_0: nxt.rdata = {cur.channel_select, cur.go,
                                     cur.module_enable_bit};
        ADDR_CONTROL_1: nxt.rdata = {cur.result_format_bit, 4'h0,
                                     cur.negative_ref_select,
                                     cur.positive_ref_select};
        ADDR_RESULT_HI: nxt.rdata = result_high_reg; // R01
        ADDR_RESULT_LO: nxt.rdata = result_low_reg;  // R01
        ADDR_IRQ_STAT:  nxt.rdata = {7'h00, cur.conversion_done_flag};
        ADDR_IRQ_MASK:  nxt.rdata = {7'h00, cur.done_mask};
        default:        nxt.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur <= '{state: ST_OFF, default: '0};
    end else begin
      cur <= nxt;
    end
  end

  // outputs
  assign o_rdata          = cur.rdata;
  assign o_dac_code       = cur.sar;
  assign o_channel_select = cur.channel_select;  // R02
  assign o_channel_valid  = chan_ok;             // R03
  assign o_sample         = (cur.state != ST_CONV) && cur.module_enable_bit;
  // high fixed code falls back to low one where absent
  assign o_positive_ref_select =
    (LOW_VOLTAGE && cur.positive_ref_select == PREF_FVR_HI) ?
    PREF_FVR_LO : cur.positive_ref_select;       // R06 R13
  assign o_negative_ref_select = cur.negative_ref_select; // R07
  assign o_irq  = cur.conversion_done_flag && cur.done_mask; // R08
  assign o_wake = cur.conversion_done_flag && cur.done_mask; // R08

  // assertions
  sequence s_last_bit;
    cur.state == ST_CONV && cur.go && cur.module_enable_bit
      && cur.bit_idx == BIT_LAST && cur.tick == TBIT_LAST;
  endsequence
  property p_done_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_last_bit |=> cur.conversion_done_flag && cur.state == ST_IDLE;
  endproperty
  a_done_flag: assert property (p_done_flag) // R10
    else $error("done flag not set at completion");
  property p_result_load;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_last_bit |=> cur.result == $past(decided);
  endproperty
  a_result_load: assert property (p_result_load) // R01
    else $error("result not loaded");
  // an unmasked completion must raise both the interrupt and wake
  property p_irq;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_last_bit ##0
       (cur.done_mask && !(i_wr && i_addr == ADDR_IRQ_MASK)))
        |=> o_irq && o_wake;
  endproperty
  a_irq: assert property (p_irq) // R08
    else $error("interrupt level wrong");
  property p_chs;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_CONTROL_0) |=>
        o_channel_select == $past(i_wdata[CTL0_CHS_LSB +: CHS_W]);
  endproperty
  a_chs: assert property (p_chs) // R02
    else $error("channel not taken");
  property p_nref;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_CONTROL_1) |=>
        o_negative_ref_select == $past(i_wdata[CTL1_NREF_BIT]);
  endproperty
  a_nref: assert property (p_nref) // R07
    else $error("negative reference not taken");
  property p_pref;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_CONTROL_1 && !LOW_VOLTAGE) |=>
        o_positive_ref_select == $past(i_wdata[CTL1_PREF_LSB +: 2]);
  endproperty
  a_pref: assert property (p_pref) // R06
    else $error("positive reference altered");
  property p_fmt;
    @(posedge i_clk) disable iff (!i_rst_n)
      {result_high_reg, result_low_reg} ==
        (cur.result_format_bit ? {6'h00, cur.result}
                               : {cur.result, 6'h00});
  endproperty
  a_fmt: assert property (p_fmt) // R11
    else $error("result pair layout wrong");
  property p_go_needs_enable;
    @(posedge i_clk) disable iff (!i_rst_n)
      (go_write && !cur.module_enable_bit && cur.state != ST_CONV)
        |=> !cur.go;
  endproperty
  a_go_needs_enable: assert property (p_go_needs_enable) // R12
    else $error("go accepted while disabled");
  // completion drops go unless software restarts in that cycle
  property p_go_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_last_bit ##0 !go_write) |=> !cur.go;
  endproperty
  a_go_clear: assert property (p_go_clear) // R10
    else $error("go not cleared at completion");
  // a start begins with the top bit on trial and sampling stopped
  property p_conv_start;
    @(posedge i_clk) disable iff (!i_rst_n)
      (cur.state == ST_IDLE && cur.module_enable_bit && cur.go) |=>
        cur.state == ST_CONV && o_dac_code == 10'h200 && !o_sample;
  endproperty
  a_conv_start: assert property (p_conv_start) // R01
    else $error("conversion did not start");
  // clearing go mid conversion ends it at once
  property p_abort;
    @(posedge i_clk) disable iff (!i_rst_n)
      (cur.state == ST_CONV && cur.module_enable_bit && !cur.go) |=>
        cur.state == ST_IDLE && !cur.go;
  endproperty
  a_abort: assert property (p_abort) // R10
    else $error("terminated conversion kept running");
endmodule : sar_adc_config_control
`default_nettype wire

// File: test/analog_src_model.sv
// comparator and analog source model facing the converter
`timescale 1ns/1ps
`default_nettype none
module analog_src_model
  import sar_adc_pkg::*;
(
  // converter side
  input  wire logic [RES_W-1:0] i_code,
  input  wire logic [CHS_W-1:0] i_chan,
  // level seen on the selected pin
  input  wire logic [RES_W-1:0] i_level,
  output logic                  o_cmp
);
  // ground channel always reads zero, pins read the set level
  always_comb begin
    if (i_chan == CH_GROUND) begin
      o_cmp = (i_code == '0);
    end else begin
      // the pin is taken as already set analog by software
      o_cmp = (i_level >= i_code);
    end
  end
endmodule : analog_src_model
`default_nettype wire

// File: test/sar_adc_config_control_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_config_control_tb;
  import sar_adc_pkg::*;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, cmp;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0, rdata, q;
  logic [9:0] dac, level = '0;
  logic [5:0] chs;
  logic [1:0] pref;
  logic       chv, smp, nref, irq, wake;
  int         err_count = 0, n_tests = 0, cyc = 0;
  sar_adc_config_control i_sar_adc_config_control (
    .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmp(cmp),
    .o_dac_code(dac), .o_channel_select(chs), .o_channel_valid(chv),
    .o_sample(smp), .o_positive_ref_select(pref),
    .o_negative_ref_select(nref), .o_irq(irq), .o_wake(wake));
  analog_src_model i_analog_src_model (
    .i_code(dac), .i_chan(chs), .i_level(level), .o_cmp(cmp));
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  task automatic summarize();
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // hang guard, well above the few conversions run here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    // let the written registers settle before callers look
    #1;
  endtask : wreg
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // all registers clear after reset, unmapped index reads zero
  task automatic t_reset();
    for (int a = 0; a < 7; a++) begin
      rreg(4'(a), q);
      chk(16'(q), 16'h0000);
    end
    chk(16'(smp), 16'h0000);
    chk(16'({irq, wake}), 16'h0000);
  endtask : t_reset
  // start without enable is dropped
  task automatic t_refuse();
    wreg(ADDR_CONTROL_0, 8'h02);
    rreg(ADDR_CONTROL_0, q);
    chk(16'(q), 16'h0000);
  endtask : t_refuse
  // every reference code reaches the analog side
  task automatic t_refs();
    for (int c = 0; c < 8; c++) begin
      wreg(ADDR_CONTROL_1, 8'(c));
      chk(16'(pref), 16'(c[1:0]));
      chk(16'(nref), 16'(c[2]));
    end
  endtask : t_refs
  // legal and illegal channel codes on the larger variant
  task automatic t_chan();
    logic [5:0] tc [5] = '{CH_PORTA_GAP, CH_PORTA_HI, CH_PORTB_LO,
                           6'h20, CH_FVR};
    logic       tv [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      wreg(ADDR_CONTROL_0, {tc[i], 2'b01});
      chk(16'(chs), 16'(tc[i]));
      chk(16'(chv), 16'(tv[i]));
    end
  endtask : t_chan
  // full conversion with format and mask choice
  task automatic t_conv(input logic [9:0] l, input logic f,
                        input logic m);
    level <= l;
    wreg(ADDR_IRQ_MASK, {7'h00, m});
    wreg(ADDR_CONTROL_0, {CH_GROUND, 2'b01});
    wreg(ADDR_CONTROL_0, {CH_PORTC_LO, 2'b01});
    repeat (8) @(posedge clk);
    wreg(ADDR_CONTROL_1, {f, 7'h00});
    chk(16'(smp), 16'h0001);
    wreg(ADDR_CONTROL_0, {CH_PORTC_LO, 2'b11});
    @(posedge clk);
    #1 chk(16'(dac), 16'h0200);
    chk(16'(smp), 16'h0000);
    q = '0;
    for (int i = 0; i < 1200 && q[0] !== 1'b1; i++) rreg(ADDR_IRQ_STAT, q);
    chk(16'(irq), 16'(m));
    chk(16'(wake), 16'(m));
    chk(16'(smp), 16'h0001);
    rreg(ADDR_CONTROL_0, q);
    chk(16'(q), 16'({CH_PORTC_LO, 2'b01}));
    rreg(ADDR_RESULT_HI, q);
    chk(16'(q), f ? 16'(l[9:8]) : 16'(l[9:2]));
    rreg(ADDR_RESULT_LO, q);
    chk(16'(q), f ? 16'(l[7:0]) : 16'({l[1:0], 6'h00}));
    wreg(ADDR_IRQ_MASK, 8'h01);
    chk(16'(irq), 16'h0001);
    wreg(ADDR_IRQ_STAT, 8'h01);
    chk(16'(irq), 16'h0000);
    rreg(ADDR_IRQ_STAT, q);
    chk(16'(q), 16'h0000);
  endtask : t_conv
  // clearing start after three decided bits keeps them and copies
  // the last one into every undecided bit
  task automatic t_abort(input logic [9:0] l);
    logic [9:0] e;
    e = {l[9:7], {7{l[7]}}};
    level <= l;
    wreg(ADDR_CONTROL_1, 8'h80);
    wreg(ADDR_CONTROL_0, {CH_PORTC_LO, 2'b11});
    repeat (700) @(posedge clk);
    wreg(ADDR_CONTROL_0, {CH_PORTC_LO, 2'b01});
    rreg(ADDR_CONTROL_0, q);
    chk(16'(q), 16'({CH_PORTC_LO, 2'b01}));
    rreg(ADDR_RESULT_HI, q);
    chk(16'(q), 16'(e[9:8]));
    rreg(ADDR_RESULT_LO, q);
    chk(16'(q), 16'(e[7:0]));
  endtask : t_abort
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_refuse();
    wreg(ADDR_CONTROL_0, 8'h01);
    t_refs();
    t_chan();
    t_conv(10'h2B5, 1'b0, 1'b1);
    t_conv(10'h0C3, 1'b1, 1'b0);
    t_abort(10'h2B5);
    summarize();
  end
endmodule : sar_adc_config_control_tb
`default_nettype wire
